/* src/rscd_decoder.sv */
/*
 * Frame decoder and configuration registers of the receiver.
 * Assumes lineBitValid marks one sampled frame bit per clock cycle it is high, synchronous to clock.
 */
`timescale 1ns/100ps
module rscd_decoder
   import rscd_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         reset,
   input  wire logic         powerLoss,
   input  wire logic         lineBitValid,
   input  wire logic         lineBit,
   input  wire logic         frameAbort,
   input  wire logic         markerCancel,
   output logic              pollReturn,
   output logic              configWrite,
   output logic              dataLineOut,
   output logic              dataLineOe,
   output rscd_opcfg_t       operating_config_reg,
   output rscd_limit_t       bitcheck_limit,
   output rscd_params_t      params
);

   //****************************************
   // Frame shift
   //****************************************
   logic [3:0]  bitCount;
   logic [14:0] frame;
   logic [14:0] next_frame;
   logic        lastBit;

   always_comb begin
      next_frame = frame;
      next_frame[bitCount] = lineBit;   // [R22]
   end

   assign lastBit = lineBitValid && (bitCount == 4'(FRAME_BITS - 1));

   always_ff @(posedge clock) begin
      if (reset || frameAbort) begin
         bitCount <= '0;
         frame    <= '0;
      end else if (lineBitValid) begin
         frame    <= lastBit ? '0 : next_frame;
         bitCount <= lastBit ? '0 : bitCount + 4'h1;
      end
   end

   //****************************************
   // Command decode and register commit
   //****************************************
   logic        isPoll;
   logic        commitOk;
   logic [11:0] dataWord;

   // Frame bit n sits at index n-1; bit 3 is the data MSB
   always_comb begin
      isPoll   = next_frame[0];                           // [R6]
      commitOk = !next_frame[0] && !next_frame[14];      // [R8]
      for (int i = 0; i < DATA_BITS; i++) begin
         dataWord[11 - i] = next_frame[2 + i];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         pollReturn  <= 1'b0;
         configWrite <= 1'b0;
      end else begin
         pollReturn  <= lastBit && isPoll;
         configWrite <= lastBit && commitOk;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         operating_config_reg <= OPCFG_RESET;             // [R5]
      end else if (lastBit && commitOk && next_frame[1]) begin
         operating_config_reg <= dataWord;                // [R7] [R10] [R23]
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         bitcheck_limit <= LIMIT_RESET;                   // [R5] [R11]
      end else if (lastBit && commitOk && !next_frame[1]) begin
         bitcheck_limit <= dataWord;                      // [R7] [R1] [R2]
      end
   end

   //****************************************
   // Derived parameters
   //****************************************
   logic [7:0] limit_scale_factor;
   logic [3:0] sleepFactor;

   always_comb begin
      limit_scale_factor = BAND0_FACTOR >> operating_config_reg.rateBand;   // [R12]
      sleepFactor        = operating_config_reg.sleepMult ? XSLEEP_HI : 4'h1; // [R19]
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         params <= '0;
      end else begin
         params.lowLimit  <= 10'(bitcheck_limit.lowBound) * 10'(limit_scale_factor); // [R13] [R21]
         params.highLimit <= (10'(bitcheck_limit.highBound) - 10'h001)
                             * 10'(limit_scale_factor);                          // [R21]
         params.checkBits <= 4'(operating_config_reg.checkCode * 3);             // [R14]
         params.sleepTicks <= 14'(operating_config_reg.sleepValue) * 14'(sleepFactor); // [R16]
         params.pollContinuous <= operating_config_reg.sleepValue == 5'h00;      // [R17]
         params.permanentSleep <= operating_config_reg.sleepValue == SLEEP_ENDLESS; // [R18]
         params.useAsk    <= operating_config_reg.modulationSelect;              // [R15]
         params.squelchOn <= operating_config_reg.noiseSquelch;                  // [R20]
      end
   end

   //****************************************
   // Power-loss marker
   //****************************************
   logic        markerOn;
   logic [11:0] markerCount;
   logic        markerLevel;

   always_ff @(posedge clock) begin
      if (reset) begin
         markerOn <= 1'b0;
      end else if (powerLoss) begin
         markerOn <= 1'b1;                                // [R3]
      end else if (markerCancel) begin
         markerOn <= 1'b0;                                // [R4]
      end
   end

   always_ff @(posedge clock) begin
      if (reset || !markerOn) begin
         markerCount <= '0;
         markerLevel <= 1'b1;
      end else if (markerCount == 12'(MARKER_HALF - 1)) begin
         markerCount <= '0;
         markerLevel <= !markerLevel;                     // [R3]
      end else begin
         markerCount <= markerCount + 12'h001;
      end
   end

   // Open drain: only ever pull low
   assign dataLineOut = 1'b0;
   assign dataLineOe  = markerOn && !markerLevel;

   //****************************************
   // Checks
   //****************************************
   AST_POLL_NO_WRITE: assert property (@(posedge clock) disable iff (reset)
      lastBit && next_frame[0] |=> !configWrite && $stable(operating_config_reg)
         && $stable(bitcheck_limit))                                             // [R6]
      else $error("poll frame altered a register");
   AST_STOP_BLOCKS: assert property (@(posedge clock) disable iff (reset)
      lastBit && next_frame[14] |=> $stable(operating_config_reg)
         && $stable(bitcheck_limit))                                             // [R8]
      else $error("stop bit one still wrote");
   AST_OPCFG_WRITE: assert property (@(posedge clock) disable iff (reset)
      lastBit && next_frame[1:0] == 2'b10 && !next_frame[14]
         |=> operating_config_reg == $past(dataWord) && $stable(bitcheck_limit)) // [R7]
      else $error("operating write wrong");
   AST_LIMIT_WRITE: assert property (@(posedge clock) disable iff (reset)
      lastBit && next_frame[1:0] == 2'b00 && !next_frame[14]
         |=> bitcheck_limit == $past(dataWord) && $stable(operating_config_reg)) // [R23]
      else $error("limit write wrong");
   AST_DEFAULTS: assert property (@(posedge clock)
      $past(reset) |-> operating_config_reg == OPCFG_RESET
         && bitcheck_limit == LIMIT_RESET)                                       // [R5]
      else $error("defaults not loaded");
   AST_LOW_LIMIT: assert property (@(posedge clock) disable iff (reset)
      !$past(reset) && $stable(bitcheck_limit) && $stable(operating_config_reg) |->
         params.lowLimit == 10'(bitcheck_limit.lowBound) * 10'(limit_scale_factor)) // [R13]
      else $error("low limit wrong");
   AST_CHECK_BITS: assert property (@(posedge clock) disable iff (reset)
      operating_config_reg.checkCode == 2'b11 ##1 $stable(operating_config_reg)
         |-> params.checkBits == 4'd9)                                           // [R14]
      else $error("check count wrong");
   AST_MARKER_HALF: assert property (@(posedge clock) disable iff (reset)
      markerOn && $rose(dataLineOe) |=> dataLineOe || !markerOn)                 // [R3]
      else $error("marker pulse too short");
   AST_SCALE_FACTOR: assert property (@(posedge clock) disable iff (reset)
      (operating_config_reg.rateBand != 2'b00 || limit_scale_factor == 8'h08)
         && (operating_config_reg.rateBand != 2'b01 || limit_scale_factor == 8'h04)
         && (operating_config_reg.rateBand != 2'b10 || limit_scale_factor == 8'h02)
         && (operating_config_reg.rateBand != 2'b11 || limit_scale_factor == 8'h01)) // [R12]
      else $error("scale factor wrong");
   AST_HIGH_LIMIT: assert property (@(posedge clock) disable iff (reset)
      !$past(reset) && $stable(bitcheck_limit) && $stable(operating_config_reg) |->
         params.highLimit == (10'(bitcheck_limit.highBound) - 10'h001)
            * 10'(limit_scale_factor))                                           // [R21]
      else $error("high limit wrong");
   AST_SLEEP_TICKS: assert property (@(posedge clock) disable iff (reset)
      !$past(reset) && $stable(operating_config_reg) |->
         params.sleepTicks == 14'(operating_config_reg.sleepValue)
            * (operating_config_reg.sleepMult ? 14'h0008 : 14'h0001))            // [R16] [R19]
      else $error("sleep ticks wrong");
   AST_POLL_CONT: assert property (@(posedge clock) disable iff (reset)
      !$past(reset) && $stable(operating_config_reg) |->
         params.pollContinuous == (operating_config_reg.sleepValue == 5'h00))    // [R17]
      else $error("continuous poll flag wrong");
   AST_PERM_SLEEP: assert property (@(posedge clock) disable iff (reset)
      !$past(reset) && $stable(operating_config_reg) |->
         params.permanentSleep == (operating_config_reg.sleepValue == 5'h1F))    // [R18]
      else $error("permanent sleep flag wrong");
   AST_MODULATION: assert property (@(posedge clock) disable iff (reset)
      !$past(reset) && $stable(operating_config_reg) |->
         params.useAsk == operating_config_reg.modulationSelect)                 // [R15]
      else $error("modulation select wrong");
   AST_SQUELCH: assert property (@(posedge clock) disable iff (reset)
      !$past(reset) && $stable(operating_config_reg) |->
         params.squelchOn == operating_config_reg.noiseSquelch)                  // [R20]
      else $error("squelch enable wrong");
   AST_WRITE_PULSE: assert property (@(posedge clock) disable iff (reset)
      configWrite |=> !configWrite)                                              // [R23]
      else $error("write pulse longer than one cycle");
   AST_OPEN_DRAIN: assert property (@(posedge clock) disable iff (reset)
      dataLineOut == 1'b0)                                                       // [R3]
      else $error("data line driven high");

   COV_OPCFG: cover property (@(posedge clock) lastBit && next_frame[1:0] == 2'b10);
   COV_LIMIT: cover property (@(posedge clock) lastBit && next_frame[1:0] == 2'b00);
   COV_POLL:  cover property (@(posedge clock) lastBit && next_frame[0]);
   COV_MARK:  cover property (@(posedge clock) $fell(markerOn));
   COV_STOP:  cover property (@(posedge clock) lastBit && next_frame[14]);

endmodule // rscd_decoder

/* src/rscd_pkg.sv */
/*
 * Constants and types for the receiver serial configuration decoder.
 * Assumes a single 250 MHz clock domain and a line bit strobe from the pin front end.
 */
// What this block does
// R1: Hold two 12-bit registers: operating configuration and bit-check limit.
// R2: Both registers are written only by serial frames on the shared data line.
// R3: After a supply-drop reset, drive the power-loss marker pattern on the data line.
// R4: Controller reprograms every relied-on register after seeing the marker.
// R5: Reset loads defaults into both registers; defaults need no programming.
// R6: Frame bit 1 set means return-to-polling; the rest is ignored.
// R7: Bit 1 clear: bit 2 set targets operating config, clear targets limit.
// R8: Commit data bits only when stop bit 15 is zero.
// R9: Controller always sends stop bit 15 as zero.
// R10: Operating fields: band, check count, modulation, sleep, multiplier, squelch.
// R11: Limit fields: low bound bits 3-8, high bound bits 9-14; defaults 21, 41.
// R12: Band 00/01/10/11 gives limit scale factor 8/4/2/1.
// R13: Low and high bounds are multiplied by the limit scale factor.
// R14: Check count 00/01/10/11 gives 0/3/6/9 bits.
// R15: Modulation select 0 is frequency shift, 1 is amplitude shift.
// R16: Sleep interval is value times multiplier times 1024 base clock periods; sleepTicks holds value times multiplier only, without the 1024.
// R17: Sleep value zero polls continuously with no sleep interval.
// R18: Sleep value 31 is permanent sleep, left only under external control.
// R19: Sleep multiplier bit gives factor 1 when clear, 8 when set.
// R20: Squelch bit set enables digital noise suppression; clear disables it.
// R21: High limit is (high bound minus one) times factor; low is bound times factor.
// R22: Frame bits arrive in ascending order, bit 1 first, bit 15 last.
// R23: Writing one register leaves the other intact; values apply after the stop bit.
package rscd_pkg;
   localparam int          FRAME_BITS     = 15;
   localparam int          DATA_BITS      = 12;
   localparam logic [11:0] OPCFG_RESET    = 12'h119;
   localparam logic [11:0] LIMIT_RESET    = 12'h5_69;
   localparam int          SLEEP_BASE     = 1024;
   localparam logic [4:0]  SLEEP_ENDLESS  = 5'h1F;
   localparam logic [3:0]  XSLEEP_HI      = 4'h8;
   // Marker half period in clocks; value is a plain default
   localparam int          MARKER_HALF    = 4000;
   localparam logic [7:0]  BAND0_FACTOR   = 8'h08;

   typedef struct packed {
      logic [1:0] rateBand;
      logic [1:0] checkCode;
      logic       modulationSelect;
      logic [4:0] sleepValue;
      logic       sleepMult;
      logic       noiseSquelch;
   } rscd_opcfg_t;

   typedef struct packed {
      logic [5:0] lowBound;
      logic [5:0] highBound;
   } rscd_limit_t;

   typedef struct packed {
      logic [9:0]  lowLimit;
      logic [9:0]  highLimit;
      logic [3:0]  checkBits;
      logic [13:0] sleepTicks;
      logic        pollContinuous;
      logic        permanentSleep;
      logic        useAsk;
      logic        squelchOn;
   } rscd_params_t;
endpackage

/* dv/rscd_ctrl_model.sv */
/*
 * Controller model that sends configuration frames bit by bit.
 * Assumes the decoder takes a bit on each rising edge with valid high.
 */
`timescale 1ns/100ps
module rscd_ctrl_model (
   input  wire logic clock,
   output logic      lineBitValid,
   output logic      lineBit
);
   initial begin
      lineBitValid = 1'b0;
      lineBit      = 1'b1;
   end

   // Call just after an edge; idle line shows the inverse of the last bit
   task automatic send_frame(input logic [14:0] frame, input int nBits);
      for (int i = 0; i < nBits; i++) begin
         lineBitValid <= 1'b1;
         lineBit      <= frame[i];
         @(posedge clock);
         #1;
      end
      lineBitValid <= 1'b0;
      lineBit      <= ~lineBit;
   endtask
endmodule // rscd_ctrl_model

/* dv/receiver_serial_config_decoder_tb.sv */
/*
 * Self-checking testbench for the configuration decoder.
 * Assumes the controller model drives the frame bit inputs.
 */
`timescale 1ns/100ps
module receiver_serial_config_decoder_tb;
   import rscd_pkg::*;
   logic         clock, reset, powerLoss, frameAbort, markerCancel;
   logic         lineBitValid, lineBit, pollReturn, configWrite;
   logic         dataLineOut, dataLineOe;
   rscd_opcfg_t  opReg, expOp;
   rscd_limit_t  limReg, expLim;
   rscd_params_t params;
   logic [4:0]   sleepTab [4] = '{5'h00, 5'h1F, 5'h05, 5'h06};
   int           fail_count = 0;
   int           checks_done = 0;

   rscd_decoder i_rscd_decoder (.clock(clock), .reset(reset), .powerLoss(powerLoss),
      .lineBitValid(lineBitValid), .lineBit(lineBit), .frameAbort(frameAbort),
      .markerCancel(markerCancel), .pollReturn(pollReturn), .configWrite(configWrite),
      .dataLineOut(dataLineOut), .dataLineOe(dataLineOe),
      .operating_config_reg(opReg), .bitcheck_limit(limReg), .params(params));
   rscd_ctrl_model i_rscd_ctrl_model (.clock(clock), .lineBitValid(lineBitValid),
      .lineBit(lineBit));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic chk_params;
      logic [7:0] f;
      f = 8'h08 >> expOp.rateBand;
      cmp(params.lowLimit, expLim.lowBound * f);
      cmp(params.highLimit, (expLim.highBound - 1) * f);
      cmp(params.checkBits, expOp.checkCode * 3);
      cmp(params.sleepTicks, expOp.sleepValue * (expOp.sleepMult ? 8 : 1));
      cmp(params.pollContinuous, expOp.sleepValue == 5'h00);
      cmp(params.permanentSleep, expOp.sleepValue == 5'h1F);
      cmp(params.useAsk, expOp.modulationSelect);
      cmp(params.squelchOn, expOp.noiseSquelch);
   endtask

   // Sends one whole frame and collects the completion pulses
   task automatic frame(input logic b1, b2, input logic [11:0] d, input logic stop,
                        input logic expWr, expPoll);
      logic [14:0] f;
      logic        wr, pl;
      f[0] = b1;
      f[1] = b2;
      f[14] = stop;
      for (int k = 0; k < 12; k++) f[2 + k] = d[11 - k];
      wr = 1'b0;
      pl = 1'b0;
      i_rscd_ctrl_model.send_frame(f, 15);
      repeat (3) begin
         wr |= configWrite;
         pl |= pollReturn;
         tick(1);
      end
      cmp(wr, expWr);
      cmp(pl, expPoll);
      cmp(opReg, expOp);
      cmp(limReg, expLim);
      chk_params;
   endtask

   initial begin
      reset = 1'b1;
      powerLoss = 1'b0;
      frameAbort = 1'b0;
      markerCancel = 1'b0;
      expOp = 12'h119;
      expLim = 12'h569;
      tick(4);
      reset <= 1'b0;
      cmp(opReg, expOp);
      cmp(limReg, expLim);
      tick(2);
      chk_params;
      $display("test reset done");
      for (int b = 0; b < 4; b++) begin
         expOp = {b[1:0], b[1:0], b[0], sleepTab[b], b[1], ~b[0]};
         frame(1'b0, 1'b1, expOp, 1'b0, 1'b1, 1'b0);
         expLim = {6'h0A + 6'(b), 6'h3F - 6'(b)};
         frame(1'b0, 1'b0, expLim, 1'b0, 1'b1, 1'b0);
      end
      $display("test fields done");
      frame(1'b0, 1'b1, ~expOp, 1'b1, 1'b0, 1'b0);
      frame(1'b1, 1'b0, 12'hABC, 1'b0, 1'b0, 1'b1);
      i_rscd_ctrl_model.send_frame(15'h0000, 7);
      frameAbort <= 1'b1;
      tick(1);
      frameAbort <= 1'b0;
      expLim = 12'h3C7;
      frame(1'b0, 1'b0, expLim, 1'b0, 1'b1, 1'b0);
      $display("test frames done");
      powerLoss <= 1'b1;
      tick(1);
      powerLoss <= 1'b0;
      tick(3990);
      cmp(dataLineOe, 1'b0);
      tick(20);
      cmp(dataLineOe, 1'b1);
      cmp(dataLineOut, 1'b0);
      tick(4000);
      cmp(dataLineOe, 1'b0);
      tick(4000);
      markerCancel <= 1'b1;
      tick(1);
      markerCancel <= 1'b0;
      tick(2);
      cmp(dataLineOe, 1'b0);
      expOp = 12'hFFF;
      frame(1'b0, 1'b1, expOp, 1'b0, 1'b1, 1'b0);
      $display("test marker done");
      stop_test;
   end

   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      stop_test;
   end
endmodule // receiver_serial_config_decoder_tb
